// [rtl/gdmr_regs.sv]
// Pin pair, datapath control and strap status register bank
`timescale 1ns/1ps
module gdmr_regs (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  // Local control bus
  input  wire gdmr_pkg::gdmr_busreq_t busReq,
  output logic [7:0]                 rdData,
  output logic                       rdValid,
  // Mode straps, already decoded to three bits each
  input  wire logic [2:0]            strapHiPin,
  input  wire logic [2:0]            strapLoPin,
  // Repeater in-band channel-B detection
  input  wire logic                  rptrMode,
  input  wire logic                  inbandChan2Valid,
  input  wire logic                  inbandChan2,
  // Video path
  input  wire logic                  pixelValidStrobe,
  output logic                       pixelForward,
  output gdmr_pkg::gdmr_dpctl_t      dpCtl,
  // General-purpose pins
  input  wire logic [1:0]            pinIn,
  output logic [1:0]                 pinOut,
  output logic [1:0]                 pinOe,
  output logic [1:0]                 pinGpioIn,
  output logic [1:0]                 pinFuncIn
);

  typedef struct packed {
    logic [7:0]            pinCfg;
    logic [7:0]            dpReg;
    logic [2:0][2:0]       strapHiSync;
    logic [2:0][2:0]       strapLoSync;
    logic [2:0]            strapHiVal;
    logic [2:0]            strapLoVal;
    logic                  strapHiDone;
    logic                  strapLoDone;
    logic [1:0]            settleCnt;
    logic [7:0]            rdData;
    logic                  rdValid;
    logic [1:0]            pinOut;
    logic [1:0]            pinOe;
    logic [1:0]            pinGpioIn;
    logic [1:0]            pinFuncIn;
    logic [2:0][1:0]       pinSync;
    logic [1:0]            pinInLvl;
    logic                  pixelForward;
    gdmr_pkg::gdmr_dpctl_t dpCtl;
  } gdmr_state_t;

  gdmr_state_t st_r;
  gdmr_state_t st_nxt;

  logic [1:0] pinMode [2];
  logic [1:0] pinLevel;
  logic       validActive;
  logic       chan2Req;

  assign pinMode[1] = st_r.pinCfg[gdmr_pkg::PIN_HI_SEL_LSB +: 2];
  assign pinMode[0] = st_r.pinCfg[gdmr_pkg::PIN_LO_SEL_LSB +: 2];
  assign pinLevel   = {st_r.pinCfg[gdmr_pkg::PIN_HI_OUT_BIT],
                       st_r.pinCfg[gdmr_pkg::PIN_LO_OUT_BIT]};

  // Strobe normalised to active high
  assign validActive = pixelValidStrobe
                       ^ st_r.dpReg[gdmr_pkg::VALID_POLARITY_BIT];

  // Repeater detection may replace the software enable
  assign chan2Req = (rptrMode && inbandChan2Valid) ? inbandChan2
                    : st_r.dpReg[gdmr_pkg::CHAN2_ENABLE_BIT];

  always_comb begin
    st_nxt = st_r;
    st_nxt.rdValid = 1'b0;

    // Register writes; strap status has no write path
    if (busReq.wrEn) begin
      unique case (busReq.addr)
        gdmr_pkg::PIN_PAIR_CONFIG_ADDR: begin
          st_nxt.pinCfg = busReq.wdata & gdmr_pkg::PIN_PAIR_WMASK;
        end
        gdmr_pkg::DATAPATH_CONTROL_ADDR: begin
          st_nxt.dpReg = busReq.wdata & gdmr_pkg::DATAPATH_WMASK;
        end
        default: begin
          st_nxt.pinCfg = st_r.pinCfg;
        end
      endcase
    end

    // Reads answer one cycle later; unmapped reads return zero
    if (busReq.rdEn) begin
      st_nxt.rdValid = 1'b1;
      unique case (busReq.addr)
        gdmr_pkg::PIN_PAIR_CONFIG_ADDR:  st_nxt.rdData = st_r.pinCfg;
        gdmr_pkg::DATAPATH_CONTROL_ADDR: st_nxt.rdData = st_r.dpReg;
        gdmr_pkg::STRAP_MODE_STATUS_ADDR: begin
          st_nxt.rdData = {st_r.strapHiDone, st_r.strapHiVal,
                           st_r.strapLoDone, st_r.strapLoVal};
        end
        default: st_nxt.rdData = 8'h00;
      endcase
    end

    // Straps settle through three flops, then latch once
    st_nxt.strapHiSync = {st_r.strapHiSync[1:0], strapHiPin};
    st_nxt.strapLoSync = {st_r.strapLoSync[1:0], strapLoPin};
    if (st_r.settleCnt != 2'h3) begin
      st_nxt.settleCnt = st_r.settleCnt + 2'h1;
    end else if (!st_r.strapHiDone) begin
      if (st_r.strapHiSync[1] == st_r.strapHiSync[2]) begin
        st_nxt.strapHiVal  = st_r.strapHiSync[2];
        st_nxt.strapHiDone = 1'b1;
      end
    end
    if (st_r.settleCnt == 2'h3 && !st_r.strapLoDone) begin
      if (st_r.strapLoSync[1] == st_r.strapLoSync[2]) begin
        st_nxt.strapLoVal  = st_r.strapLoSync[2];
        st_nxt.strapLoDone = 1'b1;
      end
    end

    // Pin inputs synchronised; accepted once stages two and three agree
    st_nxt.pinSync = {st_r.pinSync[1:0], pinIn};

    for (int i = 0; i < 2; i++) begin
      unique case (pinMode[i])
        gdmr_pkg::MODE_GPIO_OUT: begin
          st_nxt.pinOe[i]  = 1'b1;
          st_nxt.pinOut[i] = pinLevel[i];
        end
        default: begin
          st_nxt.pinOe[i]  = 1'b0;
          st_nxt.pinOut[i] = 1'b0;
        end
      endcase
      if (st_r.pinSync[1][i] == st_r.pinSync[2][i]) begin
        st_nxt.pinInLvl[i] = st_r.pinSync[2][i];
      end
      // Mode gate applied every cycle, so a mode change never leaves a stale input
      st_nxt.pinGpioIn[i] = (pinMode[i] == gdmr_pkg::MODE_GPIO_IN) & st_r.pinInLvl[i];
      st_nxt.pinFuncIn[i] = (pinMode[i] == gdmr_pkg::MODE_FUNC_IN) & st_r.pinInLvl[i];
    end

    // Datapath controls
    st_nxt.dpCtl.colourPass       = st_r.dpReg[gdmr_pkg::COLOUR_BYPASS_BIT];
    st_nxt.dpCtl.validActiveLow   = st_r.dpReg[gdmr_pkg::VALID_POLARITY_BIT];
    st_nxt.dpCtl.audioFromPins    = st_r.dpReg[gdmr_pkg::AUDIO_SOURCE_BIT];
    st_nxt.dpCtl.chan2Enabled     = st_r.dpReg[gdmr_pkg::CHAN2_OVERRIDE_BIT]
                                    & chan2Req;
    st_nxt.dpCtl.video18Bit       = st_r.dpReg[gdmr_pkg::WIDTH_SELECT_BIT];
    st_nxt.dpCtl.frameTransport   = st_r.dpReg[gdmr_pkg::TRANSPORT_SEL_BIT];
    st_nxt.dpCtl.encryptBlock     = st_r.dpReg[gdmr_pkg::COLOUR_BYPASS_BIT];
    st_nxt.dpCtl.audioPacketBlock = st_r.dpReg[gdmr_pkg::COLOUR_BYPASS_BIT];
    st_nxt.pixelForward = st_r.dpReg[gdmr_pkg::COLOUR_BYPASS_BIT] | validActive;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r        <= '0;
      st_r.pinCfg <= gdmr_pkg::PIN_PAIR_CONFIG_RST;
      st_r.dpReg  <= gdmr_pkg::DATAPATH_CONTROL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdData       = st_r.rdData;
  assign rdValid      = st_r.rdValid;
  assign pinOut       = st_r.pinOut;
  assign pinOe        = st_r.pinOe;
  assign pinGpioIn    = st_r.pinGpioIn;
  assign pinFuncIn    = st_r.pinFuncIn;
  assign pixelForward = st_r.pixelForward;
  assign dpCtl        = st_r.dpCtl;

  // Checks
  a_pin_drive_mode: assert property (@(posedge clk) disable iff (sys_rst)
    pinOe[0] |-> $past(pinMode[0]) == gdmr_pkg::MODE_GPIO_OUT)
    else $error("low pin driven outside gpio output mode");

  a_pin_drive_level: assert property (@(posedge clk) disable iff (sys_rst)
    pinOe[1] |-> pinOut[1] == $past(pinLevel[1]))
    else $error("high pin driven with wrong level");

  a_reserved_zero: assert property (@(posedge clk) disable iff (sys_rst)
    st_r.pinCfg[6] == 1'b0 && st_r.pinCfg[2] == 1'b0 && st_r.dpReg[7] == 1'b0)
    else $error("reserved bit set");

  a_bypass_forward: assert property (@(posedge clk) disable iff (sys_rst)
    $past(st_r.dpReg[gdmr_pkg::COLOUR_BYPASS_BIT]) |-> pixelForward)
    else $error("bypass did not forward pixels");

  a_bypass_blocks: assert property (@(posedge clk) disable iff (sys_rst)
    dpCtl.colourPass |-> dpCtl.encryptBlock && dpCtl.audioPacketBlock)
    else $error("bypass left encryption or audio on");

  a_chan2_override: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(st_r.dpReg[gdmr_pkg::CHAN2_OVERRIDE_BIT]) |-> !dpCtl.chan2Enabled)
    else $error("channel B on without override");

  a_width_follow: assert property (@(posedge clk) disable iff (sys_rst)
    ##1 dpCtl.video18Bit == $past(st_r.dpReg[gdmr_pkg::WIDTH_SELECT_BIT]))
    else $error("width select not followed");

  a_strap_sticky: assert property (@(posedge clk) disable iff (sys_rst)
    st_r.strapHiDone |=> st_r.strapHiDone && $stable(st_r.strapHiVal))
    else $error("latched strap changed");

  a_strap_done_time: assert property (@(posedge clk)
    $fell(sys_rst) |-> ##[1:8] st_r.strapLoDone)
    else $error("low strap not latched in time");

  a_hi_done_time: assert property (@(posedge clk)
    $fell(sys_rst) |-> ##[1:8] st_r.strapHiDone)
    else $error("high strap not latched in time");

  a_lo_strap_sticky: assert property (@(posedge clk) disable iff (sys_rst)
    st_r.strapLoDone |=> st_r.strapLoDone && $stable(st_r.strapLoVal))
    else $error("latched low strap changed");

  a_colour_flag: assert property (@(posedge clk) disable iff (sys_rst)
    dpCtl.colourPass == $past(st_r.dpReg[gdmr_pkg::COLOUR_BYPASS_BIT]))
    else $error("colour bypass flag not followed");

  a_polarity_map: assert property (@(posedge clk) disable iff (sys_rst)
    dpCtl.validActiveLow == $past(st_r.dpReg[gdmr_pkg::VALID_POLARITY_BIT]))
    else $error("valid polarity not followed");

  a_forward_gate: assert property (@(posedge clk) disable iff (sys_rst)
    pixelForward == ($past(st_r.dpReg[gdmr_pkg::COLOUR_BYPASS_BIT])
      || ($past(pixelValidStrobe) != $past(st_r.dpReg[gdmr_pkg::VALID_POLARITY_BIT]))))
    else $error("pixel forward gate wrong");

  a_audio_source: assert property (@(posedge clk) disable iff (sys_rst)
    dpCtl.audioFromPins == $past(st_r.dpReg[gdmr_pkg::AUDIO_SOURCE_BIT]))
    else $error("audio source not followed");

  a_transport_sel: assert property (@(posedge clk) disable iff (sys_rst)
    dpCtl.frameTransport == $past(st_r.dpReg[gdmr_pkg::TRANSPORT_SEL_BIT]))
    else $error("transport select not followed");

  a_chan2_source: assert property (@(posedge clk) disable iff (sys_rst)
    dpCtl.chan2Enabled == ($past(st_r.dpReg[gdmr_pkg::CHAN2_OVERRIDE_BIT])
      && (($past(rptrMode) && $past(inbandChan2Valid)) ? $past(inbandChan2)
          : $past(st_r.dpReg[gdmr_pkg::CHAN2_ENABLE_BIT]))))
    else $error("channel B enable source wrong");

  a_encrypt_mirror: assert property (@(posedge clk) disable iff (sys_rst)
    dpCtl.encryptBlock == dpCtl.colourPass)
    else $error("encryption block differs from bypass");

  a_audio_mirror: assert property (@(posedge clk) disable iff (sys_rst)
    dpCtl.audioPacketBlock == dpCtl.colourPass)
    else $error("audio packet block differs from bypass");

  a_read_latency: assert property (@(posedge clk) disable iff (sys_rst)
    rdValid == $past(busReq.rdEn))
    else $error("read answer not one cycle after request");

  a_read_hold: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(busReq.rdEn) |-> $stable(rdData))
    else $error("read data moved without a read");

  a_read_unmapped: assert property (@(posedge clk) disable iff (sys_rst)
    $past(busReq.rdEn) && $past(busReq.addr) != gdmr_pkg::PIN_PAIR_CONFIG_ADDR
      && $past(busReq.addr) != gdmr_pkg::DATAPATH_CONTROL_ADDR
      && $past(busReq.addr) != gdmr_pkg::STRAP_MODE_STATUS_ADDR |-> rdData == 8'h00)
    else $error("unmapped read not zero");

  a_read_pincfg: assert property (@(posedge clk) disable iff (sys_rst)
    $past(busReq.rdEn) && $past(busReq.addr) == gdmr_pkg::PIN_PAIR_CONFIG_ADDR
      |-> rdData == $past(st_r.pinCfg))
    else $error("pin config read wrong");

  a_read_dpreg: assert property (@(posedge clk) disable iff (sys_rst)
    $past(busReq.rdEn) && $past(busReq.addr) == gdmr_pkg::DATAPATH_CONTROL_ADDR
      |-> rdData == $past(st_r.dpReg))
    else $error("datapath read wrong");

  a_read_status: assert property (@(posedge clk) disable iff (sys_rst)
    $past(busReq.rdEn) && $past(busReq.addr) == gdmr_pkg::STRAP_MODE_STATUS_ADDR
      |-> rdData == {$past(st_r.strapHiDone), $past(st_r.strapHiVal),
                     $past(st_r.strapLoDone), $past(st_r.strapLoVal)})
    else $error("strap status read wrong");

  a_pin_write: assert property (@(posedge clk) disable iff (sys_rst)
    $past(busReq.wrEn) && $past(busReq.addr) == gdmr_pkg::PIN_PAIR_CONFIG_ADDR
      |-> st_r.pinCfg == ($past(busReq.wdata) & gdmr_pkg::PIN_PAIR_WMASK))
    else $error("pin config write lost");

  a_dp_write: assert property (@(posedge clk) disable iff (sys_rst)
    $past(busReq.wrEn) && $past(busReq.addr) == gdmr_pkg::DATAPATH_CONTROL_ADDR
      |-> st_r.dpReg == ($past(busReq.wdata) & gdmr_pkg::DATAPATH_WMASK))
    else $error("datapath write lost");

  a_status_write: assert property (@(posedge clk) disable iff (sys_rst)
    $past(busReq.wrEn) && $past(busReq.addr) == gdmr_pkg::STRAP_MODE_STATUS_ADDR
      && $past(st_r.strapHiDone) && $past(st_r.strapLoDone)
      |-> $stable(st_r.strapHiVal) && $stable(st_r.strapLoVal))
    else $error("status write changed strap state");

  // Same checks for each pin
  for (genvar gp = 0; gp < 2; gp++) begin : g_pinChk
    a_pin_oe_mode: assert property (@(posedge clk) disable iff (sys_rst)
      pinOe[gp] == ($past(pinMode[gp]) == gdmr_pkg::MODE_GPIO_OUT))
      else $error("pin drive enable does not match mode");

    a_pin_out_idle: assert property (@(posedge clk) disable iff (sys_rst)
      !pinOe[gp] |-> !pinOut[gp])
      else $error("pin level shown while not driving");

    a_pin_level: assert property (@(posedge clk) disable iff (sys_rst)
      pinOe[gp] |-> pinOut[gp] == $past(pinLevel[gp]))
      else $error("pin driven with wrong level");

    a_pin_gpio_in: assert property (@(posedge clk) disable iff (sys_rst)
      pinGpioIn[gp] |-> $past(pinMode[gp]) == gdmr_pkg::MODE_GPIO_IN)
      else $error("gpio input outside gpio input mode");

    a_pin_func_in: assert property (@(posedge clk) disable iff (sys_rst)
      pinFuncIn[gp] |-> $past(pinMode[gp]) == gdmr_pkg::MODE_FUNC_IN)
      else $error("functional input outside functional mode");

    a_pin_tristate: assert property (@(posedge clk) disable iff (sys_rst)
      $past(pinMode[gp]) == gdmr_pkg::MODE_TRISTATE
        |-> !pinOe[gp] && !pinGpioIn[gp] && !pinFuncIn[gp])
      else $error("tristate pin not idle");
  end
endmodule

// [rtl/gdmr_pkg.sv]
// Package for the pin, datapath and strap register bank
package gdmr_pkg;
  // Register offsets on the local control bus
  localparam logic [7:0] PIN_PAIR_CONFIG_ADDR   = 8'h11;
  localparam logic [7:0] DATAPATH_CONTROL_ADDR  = 8'h12;
  localparam logic [7:0] STRAP_MODE_STATUS_ADDR = 8'h13;

  // Reset values
  localparam logic [7:0] PIN_PAIR_CONFIG_RST  = 8'h00;
  localparam logic [7:0] DATAPATH_CONTROL_RST = 8'h00;

  // Pin configuration fields
  localparam int PIN_HI_OUT_BIT   = 7;
  localparam int PIN_HI_SEL_LSB   = 4;
  localparam int PIN_LO_OUT_BIT   = 3;
  localparam int PIN_LO_SEL_LSB   = 0;
  localparam logic [7:0] PIN_PAIR_WMASK = 8'hbb;

  // Datapath fields
  localparam int COLOUR_BYPASS_BIT   = 6;
  localparam int VALID_POLARITY_BIT  = 5;
  localparam int AUDIO_SOURCE_BIT    = 4;
  localparam int CHAN2_OVERRIDE_BIT  = 3;
  localparam int WIDTH_SELECT_BIT    = 2;
  localparam int TRANSPORT_SEL_BIT   = 1;
  localparam int CHAN2_ENABLE_BIT    = 0;
  localparam logic [7:0] DATAPATH_WMASK = 8'h7f;

  // Strap status fields
  localparam int STRAP_HI_LATCHED_BIT = 7;
  localparam int STRAP_HI_VALUE_LSB   = 4;
  localparam int STRAP_LO_LATCHED_BIT = 3;
  localparam int STRAP_LO_VALUE_LSB   = 0;

  // Pin mode codes {direction, enable}
  localparam logic [1:0] MODE_FUNC_IN  = 2'h0;
  localparam logic [1:0] MODE_TRISTATE = 2'h2;
  localparam logic [1:0] MODE_GPIO_OUT = 2'h1;
  localparam logic [1:0] MODE_GPIO_IN  = 2'h3;

  typedef enum logic [1:0] {
    GDMR_FUNC_IN,
    GDMR_TRISTATE,
    GDMR_GPIO_OUT,
    GDMR_GPIO_IN
  } gdmr_pinmode_t;

  // Register bus request
  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gdmr_busreq_t;

  // Datapath controls as seen by the video and audio logic
  typedef struct packed {
    logic colourPass;
    logic validActiveLow;
    logic audioFromPins;
    logic chan2Enabled;
    logic video18Bit;
    logic frameTransport;
    logic encryptBlock;
    logic audioPacketBlock;
  } gdmr_dpctl_t;
endpackage

// [verif/gdmr_regs_test.sv]
// Self-checking bench for the pin, datapath and strap register bank
`timescale 1ns/1ps
module gdmr_regs_test;
  logic                  clk       = 1'b0;
  logic                  sysRst    = 1'b1;
  gdmr_pkg::gdmr_busreq_t busReq   = '0;
  logic [2:0]            strapHi   = 3'h0;
  logic [2:0]            strapLo   = 3'h0;
  logic                  rptrMode  = 1'b0;
  logic                  icValid   = 1'b0;
  logic                  icVal     = 1'b0;
  logic                  strobe    = 1'b0;
  logic [1:0]            pinIn     = 2'h0;
  logic [7:0]            rdData;
  logic                  rdValid;
  logic                  pixelForward;
  gdmr_pkg::gdmr_dpctl_t dpCtl;
  logic [1:0]            pinOut, pinOe, pinGpioIn, pinFuncIn;
  logic [31:0]           seed      = 32'h02f3d108;
  logic [31:0]           r;
  logic [7:0]            sts;
  logic [1:0]            m;
  int                    errorCnt  = 0;
  int                    nTests    = 0;
  int                    cycles    = 0;

  gdmr_regs dut (.clk(clk), .sys_rst(sysRst), .busReq(busReq), .rdData(rdData),
    .rdValid(rdValid), .strapHiPin(strapHi), .strapLoPin(strapLo), .rptrMode(rptrMode),
    .inbandChan2Valid(icValid), .inbandChan2(icVal), .pixelValidStrobe(strobe),
    .pixelForward(pixelForward), .dpCtl(dpCtl), .pinIn(pinIn), .pinOut(pinOut),
    .pinOe(pinOe), .pinGpioIn(pinGpioIn), .pinFuncIn(pinFuncIn));

  always #2.5 clk = ~clk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic gdmr_pkg::gdmr_dpctl_t expCtl(logic [7:0] b, logic rp, logic iv,
                                                   logic ic);
    // In-band detection wins only in a repeater with a valid detection
    return {b[6], b[5], b[4], b[3] & ((rp & iv) ? ic : b[0]), b[2], b[1], b[6], b[6]};
  endfunction

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    nTests++;
    if (seen !== exp) begin
      errorCnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    if (errorCnt == 0 && nTests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    busReq.wrEn  = 1'b1;
    busReq.addr  = a;
    busReq.wdata = d;
    @(negedge clk);
    busReq.wrEn  = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    busReq.rdEn = 1'b1;
    busReq.addr = a;
    @(negedge clk);
    busReq.rdEn = 1'b0;
    chk("rdValid", {7'h0, rdValid}, 8'h01);
    chk("rdData", rdData, exp);
  endtask

  initial begin
    r = rnd();
    strapHi = r[2:0];
    strapLo = r[6:4];
    repeat (8) @(negedge clk);
    sysRst = 1'b0;
    chk("dpCtl", dpCtl, 8'h00);
    chk("pinOe", {6'h0, pinOe}, 8'h00);
    rd(gdmr_pkg::PIN_PAIR_CONFIG_ADDR, gdmr_pkg::PIN_PAIR_CONFIG_RST);
    rd(gdmr_pkg::DATAPATH_CONTROL_ADDR, gdmr_pkg::DATAPATH_CONTROL_RST);
    repeat (10) @(negedge clk);
    sts = {1'b1, strapHi, 1'b1, strapLo};
    rd(gdmr_pkg::STRAP_MODE_STATUS_ADDR, sts);
    wr(gdmr_pkg::STRAP_MODE_STATUS_ADDR, ~sts);
    rd(gdmr_pkg::STRAP_MODE_STATUS_ADDR, sts);
    rd(8'h20, 8'h00);
    // First two passes are fixed corners: every writable and reserved bit set, then both pins as driven-high outputs
    for (int i = 0; i < 48; i++) begin
      r = (i == 0) ? 32'h3ff : (i == 1) ? 32'h199 : rnd();
      pinIn = r[9:8];
      wr(gdmr_pkg::PIN_PAIR_CONFIG_ADDR, r[7:0]);
      rd(gdmr_pkg::PIN_PAIR_CONFIG_ADDR, r[7:0] & gdmr_pkg::PIN_PAIR_WMASK);
      repeat (6) @(negedge clk);
      for (int j = 0; j < 2; j++) begin
        m = j ? r[5:4] : r[1:0];
        chk("pinOe", {7'h0, pinOe[j]}, {7'h0, m == gdmr_pkg::MODE_GPIO_OUT});
        chk("pinOut", {7'h0, pinOut[j]},
            {7'h0, (m == gdmr_pkg::MODE_GPIO_OUT) & (j ? r[7] : r[3])});
        chk("pinGpioIn", {7'h0, pinGpioIn[j]},
            {7'h0, (m == gdmr_pkg::MODE_GPIO_IN) & pinIn[j]});
        chk("pinFuncIn", {7'h0, pinFuncIn[j]},
            {7'h0, (m == gdmr_pkg::MODE_FUNC_IN) & pinIn[j]});
      end
    end
    for (int i = 0; i < 48; i++) begin
      r = (i == 0) ? 32'h0fff : rnd();
      rptrMode = r[8];
      icValid  = r[9];
      icVal    = r[10];
      strobe   = r[11];
      wr(gdmr_pkg::DATAPATH_CONTROL_ADDR, r[7:0]);
      rd(gdmr_pkg::DATAPATH_CONTROL_ADDR, r[7:0] & gdmr_pkg::DATAPATH_WMASK);
      repeat (3) @(negedge clk);
      chk("dpCtl", dpCtl, expCtl(r[7:0], r[8], r[9], r[10]));
      chk("pixelForward", {7'h0, pixelForward}, {7'h0, r[6] | (r[11] ^ r[5])});
    end
    results();
  end

  // Ceiling well above the roughly 850 cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errorCnt++;
      results();
    end
  end
endmodule
